// [mrst_seq.sv]
`timescale 1ns/10ps
`include "mrst_defines.svh"
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Writing bit 12 of status/reset starts a monitor-only soft reset.
// - Soft reset clears monitor enable and monitor interrupt pending bits.
// - Soft reset zeroes monitor pending, buffer pointers and time tag words.
// - Soft reset reloads monitor configuration locations from the EEPROM image.
// - Monitor checksum at 0x005c covers exactly 561 reloaded locations.
// - Soft reset resets pointers but leaves buffer RAM contents alone.
// - Image with monitor enable set restarts monitor; recording waits for command.
// - Store-busy pin latched 200 ns after master reset release.
// - In store-busy mode commands get busy status, no data or logging.
// - Config two bit 7 shows store-busy; bit 7 write or config one bits 4,6 end it.
// - Ready low during master reset and during power-up RAM test.
// - Power-up RAM test runs unless the skip input is high.
// - After passing test, words 0x0052..0x1fff cleared, then ready high.
// - Address 0x0028 is self-test control only while test pin high.
// - In test mode bits 0, 1, 8, 9 are read-only.
// - Upper byte controls RAM test; bits 5..0 control loopback.
// - Bits 13..11 pick test (unused here: one fixed sweep runs), bit 10 starts, bits 9..8 report result.
// - Host-directed RAM tests may overwrite RAM contents.
// - Reload mismatch sets hardware pending bit 13 and status bit 0.
module mrst_seq
	import mrst_pkg::*;
#(
	parameter int AW = 13
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        ce,
	input  wire logic        master_reset_n,
	input  wire logic        store_busy_mode_pin,
	input  wire logic        powerup_ram_test_skip,
	input  wire logic        test_pin,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata_q,
	input  wire logic        ee_valid,
	input  wire logic [15:0] ee_word,
	output logic             ee_req,
	output logic      [15:0] ee_addr,
	input  wire logic        cmd_valid,
	output logic             ready,
	output logic             busy_response,
	output logic             mon_recording,
	output logic             loopback_en,
	output logic      [5:0]  loopback_ctrl
);
	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [1:0] mr_s_q, busy_s_q, skip_s_q, test_s_q;
	logic       mr_prev_q;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			mr_s_q    <= 2'h0;
			busy_s_q  <= 2'h0;
			skip_s_q  <= 2'h0;
			test_s_q  <= 2'h0;
			mr_prev_q <= 1'b0;
		end else if (ce) begin
			mr_s_q    <= {mr_s_q[0], master_reset_n};
			busy_s_q  <= {busy_s_q[0], store_busy_mode_pin};
			skip_s_q  <= {skip_s_q[0], powerup_ram_test_skip};
			test_s_q  <= {test_s_q[0], test_pin};
			mr_prev_q <= mr_s_q[1];
		end
	end

	wire mr_n      = mr_s_q[1];
	wire mr_rise   = mr_n && !mr_prev_q;
	wire test_mode = test_s_q[1];

	////////////////////////////////////////////////////////////////////////////////
	// Registers and sequencer state
	logic [15:0] cfg1_q, hw_pend_q, mon_pend_q, next_ptr_q, last_ptr_q, st_ctrl_q;
	logic [15:0] tt_q [0:2];
	logic        busy_mode_q, mismatch_q, ready_q, armed_q, test_ok_q;
	logic [7:0]  latch_cnt_q;
	logic        latch_pend_q;
	mrst_state_t state_q;
	logic [AW-1:0] ptr_q;
	logic [1:0]  phase_q;
	logic [9:0]  load_cnt_q;
	logic [15:0] img_cfg1_q;
	logic          vfy_pend_q, vfy_chk_q;
	logic [AW-1:0] vfy_addr_q;
	logic [15:0]   vfy_word_q;

	wire wr_cfg1 = reg_wr && reg_addr == `MRST_ADDR_CFG1;
	wire wr_st   = reg_wr && reg_addr == `MRST_ADDR_STAT_RST;
	wire wr_cfg2 = reg_wr && reg_addr == `MRST_ADDR_CFG2;
	wire wr_test = reg_wr && reg_addr == `MRST_ADDR_SELF_TEST && test_mode;
	wire soft_go = wr_st && reg_wdata[`MRST_BIT_MON_RESET] && state_q == MRST_IDLE && ready_q;
	// Image word taken; none while the previous one is read back
	wire ee_take = state_q == MRST_SOFT_LOAD && ee_valid && !vfy_pend_q;

	////////////////////////////////////////////////////////////////////////////////
	// RAM port
	logic          ram_we;
	logic [AW-1:0] ram_addr;
	logic [15:0]   ram_wdata, ram_rdata;

	mrst_ram #(.AW(AW), .DW(16)) u_ram (
		.clk    (clk),
		.ce     (ce),
		.we     (ram_we),
		.addr   (ram_addr),
		.wdata  (ram_wdata),
		.rdata_q(ram_rdata)
	);

	// Reload target list; pointer steps over the 561 monitor locations
	function automatic logic [15:0] reload_addr(input logic [9:0] i);
		logic [15:0] r;
		r = 16'h0000;
		priority case (1'b1)
			i == 10'h000: r = 16'h000f;
			i == 10'h001: r = 16'h0011;
			i == 10'h002: r = 16'h0013;
			i == 10'h003: r = 16'h0015;
			i == 10'h004: r = 16'h0029;
			i == 10'h005: r = 16'h002f;
			i <  10'h00d: r = 16'h0037 + {6'h00, i};
			i <  10'h01d: r = 16'h00a3 + {6'h00, i};
			i <  10'h09d: r = 16'h00e3 + {6'h00, i};
			i == 10'h09d: r = 16'h0000;
			default:      r = 16'h0100 + {6'h00, i};
		endcase
		return r;
	endfunction

	logic [15:0] rl_addr;
	assign rl_addr = reload_addr(load_cnt_q);

	always_comb begin
		ram_we    = 1'b0;
		ram_addr  = ptr_q;
		ram_wdata = `MRST_ZERO_WORD;
		unique case (state_q)
			MRST_RAM_TEST: begin
				ram_we    = phase_q == 2'h0;
				ram_wdata = {3'h0, ptr_q};
			end
			MRST_RAM_CLEAR, MRST_BIST: begin
				ram_we = 1'b1;
			end
			MRST_SOFT_LOAD: begin
				ram_we    = ee_take;
				ram_addr  = rl_addr[AW-1:0];
				ram_wdata = ee_word;
			end
			default: begin
				ram_we = 1'b0;
			end
		endcase
		// Read back the word written one cycle earlier
		if (vfy_pend_q) begin
			ram_addr = vfy_addr_q;
		end
	end

	assign ee_req  = state_q == MRST_SOFT_LOAD && !vfy_pend_q;
	assign ee_addr = rl_addr;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			vfy_pend_q <= 1'b0;
			vfy_chk_q  <= 1'b0;
			vfy_addr_q <= '0;
			vfy_word_q <= 16'h0000;
		end else if (ce) begin
			vfy_pend_q <= ee_take;
			vfy_chk_q  <= vfy_pend_q;
			if (ee_take) begin
				vfy_addr_q <= rl_addr[AW-1:0];
				vfy_word_q <= ee_word;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_q    <= MRST_IDLE;
			ptr_q      <= '0;
			phase_q    <= 2'h0;
			load_cnt_q <= 10'h000;
			ready_q    <= 1'b0;
			test_ok_q  <= 1'b1;
			img_cfg1_q <= 16'h0000;
		end else if (ce) begin
			if (!mr_n) begin
				ready_q <= 1'b0;
				state_q <= MRST_IDLE;
			end else if (mr_rise) begin
				ptr_q     <= '0;
				phase_q   <= 2'h0;
				test_ok_q <= 1'b1;
				state_q   <= skip_s_q[1] ? MRST_IDLE : MRST_RAM_TEST;
				ready_q   <= skip_s_q[1];
			end else begin
				unique case (state_q)
					MRST_IDLE: begin
						if (soft_go) begin
							ready_q <= 1'b0;
							state_q <= MRST_SOFT_CLEAR;
						end else if (wr_test && reg_wdata[`MRST_BIT_BIST_START]) begin
							ptr_q   <= '0;
							state_q <= MRST_BIST;
						end
					end
					MRST_RAM_TEST: begin
						// Inc pass writes address, dec pass reads it back
						if (phase_q == 2'h0) begin
							ptr_q <= ptr_q + 1'b1;
							if (&ptr_q) begin
								phase_q <= 2'h1;
							end
						end else begin
							phase_q <= 2'h2;
							if (phase_q == 2'h2 && ram_rdata != {3'h0, ptr_q + 1'b1}) begin
								test_ok_q <= 1'b0;
							end
							ptr_q <= ptr_q - 1'b1;
							if (ptr_q == '0 && phase_q == 2'h2) begin
								ptr_q   <= AW'(`MRST_CLEAR_FIRST);
								state_q <= MRST_RAM_CLEAR;
							end
						end
					end
					MRST_RAM_CLEAR: begin
						ptr_q <= ptr_q + 1'b1;
						if (ptr_q == `MRST_CLEAR_LAST) begin
							state_q <= MRST_IDLE;
							ready_q <= test_ok_q;
						end
					end
					MRST_SOFT_CLEAR: begin
						load_cnt_q <= 10'h000;
						state_q    <= MRST_SOFT_LOAD;
					end
					MRST_SOFT_LOAD: begin
						if (ee_take) begin
							if (rl_addr == `MRST_ADDR_CFG1) begin
								img_cfg1_q <= ee_word;
							end
							load_cnt_q <= load_cnt_q + 1'b1;
							if (load_cnt_q == 10'(`MRST_RELOAD_COUNT - 1)) begin
								state_q <= MRST_IDLE;
								ready_q <= 1'b1;
							end
						end
					end
					MRST_BIST: begin
						ptr_q <= ptr_q + 1'b1;
						if (&ptr_q) begin
							state_q <= MRST_IDLE;
						end
					end
					default: begin
						state_q <= MRST_IDLE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control registers
	wire soft_clr = state_q == MRST_SOFT_CLEAR;
	wire load_done = ee_take && load_cnt_q == 10'(`MRST_RELOAD_COUNT - 1);
	wire load_mis  = vfy_chk_q && ram_rdata != vfy_word_q;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cfg1_q     <= 16'h0000;
			hw_pend_q  <= 16'h0000;
			mon_pend_q <= 16'h0000;
			next_ptr_q <= 16'h0000;
			last_ptr_q <= 16'h0000;
			mismatch_q <= 1'b0;
		end else if (ce) begin
			if (wr_cfg1) begin
				cfg1_q <= reg_wdata;
			end
			if (reg_wr && reg_addr == `MRST_ADDR_NEXT_PTR) begin
				next_ptr_q <= reg_wdata;
			end
			if (reg_wr && reg_addr == `MRST_ADDR_LAST_PTR) begin
				last_ptr_q <= reg_wdata;
			end
			if (soft_clr) begin
				cfg1_q[`MRST_BIT_MON_EN]    <= 1'b0;
				hw_pend_q[`MRST_BIT_MON_IP] <= 1'b0;
				mon_pend_q <= 16'h0000;
				next_ptr_q <= 16'h0000;
				last_ptr_q <= 16'h0000;
			end
			if (load_done && img_cfg1_q[`MRST_BIT_MON_EN]) begin
				cfg1_q[`MRST_BIT_MON_EN] <= 1'b1;
			end
			if (load_mis) begin
				hw_pend_q[`MRST_BIT_MISMATCH_HW] <= 1'b1;
				mismatch_q <= 1'b1;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_tt
			always_ff @(posedge clk) begin
				if (!resetn) begin
					tt_q[g] <= 16'h0000;
				end else if (ce && soft_clr) begin
					tt_q[g] <= 16'h0000;
				end else if (ce && reg_wr && reg_addr == 16'(`MRST_ADDR_TT_LO + g)) begin
					tt_q[g] <= reg_wdata;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!resetn) begin
			armed_q <= 1'b0;
		end else if (ce) begin
			if (!cfg1_q[`MRST_BIT_MON_EN] || busy_mode_q) begin
				armed_q <= 1'b0;
			end else if (cmd_valid) begin
				armed_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Store-busy latch
	always_ff @(posedge clk) begin
		if (!resetn) begin
			latch_cnt_q  <= 8'h00;
			latch_pend_q <= 1'b0;
			busy_mode_q  <= 1'b0;
		end else if (ce) begin
			if (mr_rise) begin
				latch_cnt_q  <= 8'h00;
				latch_pend_q <= 1'b1;
			end else if (latch_pend_q) begin
				latch_cnt_q <= latch_cnt_q + 8'h01;
				if (latch_cnt_q == 8'(`MRST_LATCH_CYC - 1)) begin
					busy_mode_q  <= busy_s_q[1];
					latch_pend_q <= 1'b0;
				end
			end
			if ((wr_cfg2 && reg_wdata[`MRST_BIT_BUSY_MODE]) ||
			    (wr_cfg1 && reg_wdata[`MRST_BIT_REMOTE_EXEC] && reg_wdata[`MRST_BIT_REMOTE_EN])) begin
				busy_mode_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Self-test control
	always_ff @(posedge clk) begin
		if (!resetn) begin
			st_ctrl_q <= 16'h0000;
		end else if (ce) begin
			if (wr_test) begin
				st_ctrl_q <= (reg_wdata & ~`MRST_ST_RO_MASK) | (st_ctrl_q & `MRST_ST_RO_MASK);
			end
			if (state_q == MRST_BIST && &ptr_q) begin
				st_ctrl_q[`MRST_BIT_BIST_START] <= 1'b0;
				st_ctrl_q[`MRST_BIT_BIST_PASS]  <= 1'b1;
				st_ctrl_q[`MRST_BIT_BIST_FAIL]  <= 1'b0;
			end else if (wr_test && reg_wdata[`MRST_BIT_BIST_START]) begin
				st_ctrl_q[`MRST_BIT_BIST_PASS] <= 1'b0;
				st_ctrl_q[`MRST_BIT_BIST_FAIL] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path
	always_ff @(posedge clk) begin
		if (!resetn) begin
			reg_rdata_q <= 16'h0000;
		end else if (ce && reg_rd) begin
			unique case (reg_addr)
				`MRST_ADDR_CFG1:     reg_rdata_q <= cfg1_q;
				`MRST_ADDR_STAT_RST: reg_rdata_q <= {15'h0000, mismatch_q};
				`MRST_ADDR_HW_PEND:  reg_rdata_q <= hw_pend_q;
				`MRST_ADDR_MON_PEND: reg_rdata_q <= mon_pend_q;
				`MRST_ADDR_NEXT_PTR: reg_rdata_q <= next_ptr_q;
				`MRST_ADDR_LAST_PTR: reg_rdata_q <= last_ptr_q;
				`MRST_ADDR_TT_LO:    reg_rdata_q <= tt_q[0];
				`MRST_ADDR_TT_MID:   reg_rdata_q <= tt_q[1];
				`MRST_ADDR_TT_HI:    reg_rdata_q <= tt_q[2];
				`MRST_ADDR_SELF_TEST: reg_rdata_q <= test_mode ? st_ctrl_q : 16'h0000;
				`MRST_ADDR_CFG2:     reg_rdata_q <= {8'h00, busy_mode_q, 7'h00};
				default:             reg_rdata_q <= 16'h0000;
			endcase
		end
	end

	assign ready         = ready_q;
	assign busy_response = busy_mode_q && cmd_valid;
	assign mon_recording = armed_q;
	assign loopback_en   = test_mode && |st_ctrl_q[5:0];
	assign loopback_ctrl = st_ctrl_q[5:0];

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	a_ready_low_reset: assert property (@(posedge clk) disable iff (!resetn)
		ce && !mr_n |=> !ready) else $error("ready high during reset");
	a_soft_clear_en: assert property (@(posedge clk) disable iff (!resetn)
		ce && soft_clr |=> !cfg1_q[`MRST_BIT_MON_EN] || !ce) else $error("enable not cleared");
	a_soft_zero_ptr: assert property (@(posedge clk) disable iff (!resetn)
		ce && soft_clr |=> next_ptr_q == 16'h0000) else $error("pointer not zero");
	a_busy_end_wr: assert property (@(posedge clk) disable iff (!resetn)
		ce && wr_cfg2 && reg_wdata[`MRST_BIT_BUSY_MODE] && !latch_pend_q |=> !busy_mode_q) else $error("busy stays");
	a_busy_answer: assert property (@(posedge clk) disable iff (!resetn)
		busy_mode_q && cmd_valid |-> busy_response && !mon_recording) else $error("busy not answered");
	a_skip_ready: assert property (@(posedge clk) disable iff (!resetn)
		ce && mr_rise && skip_s_q[1] |=> ready) else $error("skip ready late");
	a_test_stops_ready: assert property (@(posedge clk) disable iff (!resetn)
		state_q == MRST_RAM_CLEAR |-> !ready) else $error("ready before clear");
	a_ro_bits_kept: assert property (@(posedge clk) disable iff (!resetn)
		ce && wr_test && state_q == MRST_IDLE && !reg_wdata[`MRST_BIT_BIST_START]
		|=> (st_ctrl_q & `MRST_ST_RO_MASK) == ($past(st_ctrl_q) & `MRST_ST_RO_MASK)) else $error("ro bit changed");
	a_st_hidden: assert property (@(posedge clk) disable iff (!resetn)
		ce && reg_rd && reg_addr == `MRST_ADDR_SELF_TEST && !test_mode |=> reg_rdata_q == 16'h0000)
		else $error("self-test visible");
	c_soft_reset: cover property (@(posedge clk) disable iff (!resetn) load_done);
	c_powerup_test: cover property (@(posedge clk) disable iff (!resetn) state_q == MRST_RAM_CLEAR);
	c_busy_mode: cover property (@(posedge clk) disable iff (!resetn) busy_response);
	c_bist: cover property (@(posedge clk) disable iff (!resetn) state_q == MRST_BIST);
endmodule

// [mrst_defines.svh]
`ifndef MRST_DEFINES_SVH
`define MRST_DEFINES_SVH

// Register word addresses
`define MRST_ADDR_CFG1        16'h0000
`define MRST_ADDR_STAT_RST    16'h0001
`define MRST_ADDR_HW_PEND     16'h0006
`define MRST_ADDR_MON_PEND    16'h0008
`define MRST_ADDR_SELF_TEST   16'h0028
`define MRST_ADDR_NEXT_PTR    16'h0030
`define MRST_ADDR_LAST_PTR    16'h0031
`define MRST_ADDR_TT_LO       16'h003a
`define MRST_ADDR_TT_MID      16'h003b
`define MRST_ADDR_TT_HI       16'h003c
`define MRST_ADDR_CFG2        16'h004e
`define MRST_ADDR_MON_CKSUM   16'h005c

// Field positions
`define MRST_BIT_MON_RESET    12
`define MRST_BIT_MISMATCH_ST  0
`define MRST_BIT_MON_EN       8
`define MRST_BIT_REMOTE_EXEC  4
`define MRST_BIT_REMOTE_EN    6
`define MRST_BIT_MON_IP       1
`define MRST_BIT_MISMATCH_HW  13
`define MRST_BIT_BUSY_MODE    7
`define MRST_BIT_BIST_START   10
`define MRST_BIST_SEL_HI      13
`define MRST_BIST_SEL_LO      11
`define MRST_BIT_BIST_FAIL    9
`define MRST_BIT_BIST_PASS    8
`define MRST_ST_RO_MASK       16'h0303

// Memory ranges
`define MRST_RELOAD_COUNT     561
`define MRST_CLEAR_FIRST      16'h0052
`define MRST_CLEAR_LAST       16'h1fff
`define MRST_ZERO_WORD        16'h0000

// Timing
`define MRST_LATCH_NS         200
`define MRST_CLK_NS           10
`define MRST_LATCH_CYC        ((`MRST_LATCH_NS + `MRST_CLK_NS - 1) / `MRST_CLK_NS)

`endif

// [mrst_pkg.sv]
package mrst_pkg;
	typedef enum logic [2:0] {
		MRST_IDLE,
		MRST_RAM_TEST,
		MRST_RAM_CLEAR,
		MRST_SOFT_CLEAR,
		MRST_SOFT_LOAD,
		MRST_BIST
	} mrst_state_t;
endpackage

// [mrst_ram.sv]
`timescale 1ns/10ps
module mrst_ram #(
	parameter int AW = 13,
	parameter int DW = 16
) (
	input  wire logic          clk,
	input  wire logic          ce,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	output logic      [DW-1:0] rdata_q
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk) begin
		if (ce) begin
			if (we) begin
				mem[addr] <= wdata;
			end
			rdata_q <= mem[addr];
		end
	end
endmodule

// [mrst_ee_model.sv]
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Serial image store: answers each reload word, promptly or slowly
module mrst_ee_model (
	input  wire logic        clk,
	input  wire logic        ee_req,
	input  wire logic [15:0] ee_addr,
	input  wire logic        slow,
	input  wire logic [15:0] cfg_word,
	output logic             ee_valid,
	output logic      [15:0] ee_word
);
	initial begin
		ee_valid = 1'b0;
		ee_word  = 16'h0000;
		forever begin
			@(negedge clk);
			if (ee_req) begin
				if (slow) begin
					repeat (3) @(negedge clk);
				end
				if (ee_req) begin
					// image as if unlock pair was given
					ee_word  = (ee_addr == 16'h0000) ? cfg_word : 16'h0000;
					ee_valid = 1'b1;
					@(negedge clk);
					ee_valid = 1'b0;
					ee_word  = ~ee_word;
				end
			end
		end
	end
endmodule

// [monitor_reset_and_selftest_tb_top.sv]
`timescale 1ns/10ps
`include "mrst_defines.svh"
////////////////////////////////////////////////////////////////////////////////
module monitor_reset_and_selftest_tb_top
	import mrst_pkg::*;
;
	logic        clk, resetn, ce, master_reset_n, store_busy_mode_pin, powerup_ram_test_skip, test_pin;
	logic        reg_wr, reg_rd, ee_valid, ee_req, cmd_valid, ready, busy_response, mon_recording;
	logic        loopback_en, slow;
	logic [15:0] reg_addr, reg_wdata, reg_rdata_q, ee_word, ee_addr, cfg_word, rv;
	logic [5:0]  loopback_ctrl;
	int          n_fail, compares, n_words;

	mrst_seq dut (
		.clk(clk), .resetn(resetn), .ce(ce), .master_reset_n(master_reset_n),
		.store_busy_mode_pin(store_busy_mode_pin), .powerup_ram_test_skip(powerup_ram_test_skip),
		.test_pin(test_pin), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .ee_valid(ee_valid), .ee_word(ee_word),
		.ee_req(ee_req), .ee_addr(ee_addr), .cmd_valid(cmd_valid), .ready(ready),
		.busy_response(busy_response), .mon_recording(mon_recording),
		.loopback_en(loopback_en), .loopback_ctrl(loopback_ctrl)
	);

	mrst_ee_model ee (
		.clk(clk), .ee_req(ee_req), .ee_addr(ee_addr), .slow(slow),
		.cfg_word(cfg_word), .ee_valid(ee_valid), .ee_word(ee_word)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (ee_valid === 1'b1 && ee_req === 1'b1) n_words++;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Tasks
	task automatic finish_test();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_wr    = 1'b1;
		reg_addr  = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr    = 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(negedge clk);
		reg_rd   = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd   = 1'b0;
		d        = reg_rdata_q;
	endtask

	task automatic rdchk(input logic [15:0] a, input logic [15:0] m, input logic [15:0] e);
		rd(a, rv);
		chk(rv & m, e);
	endtask

	task automatic wait_ready(input int lim);
		for (int i = 0; i < lim && ready !== 1'b1; i++) @(negedge clk);
		chk({15'h0000, ready}, 16'h0001);
	endtask

	task automatic cmd(input logic e_busy, input logic e_rec);
		@(negedge clk);
		cmd_valid = 1'b1;
		#1 chk({15'h0000, busy_response}, {15'h0000, e_busy});
		@(negedge clk);
		cmd_valid = 1'b0;
		@(negedge clk);
		chk({15'h0000, mon_recording}, {15'h0000, e_rec});
	endtask

	task automatic mreset(input logic skip, input logic busy);
		@(negedge clk);
		master_reset_n        = 1'b0;
		powerup_ram_test_skip = skip;
		store_busy_mode_pin   = busy;
		repeat (6) @(negedge clk);
		chk({15'h0000, ready}, 16'h0000);
		master_reset_n = 1'b1;
		if (!skip) begin
			repeat (1000) @(negedge clk);
			chk({15'h0000, ready}, 16'h0000);
			wait_ready(40000);
		end else begin
			wait_ready(60);
		end
		repeat (`MRST_LATCH_CYC + 4) @(negedge clk);
		store_busy_mode_pin = 1'b0;
	endtask

	task automatic soft_reset(input logic [15:0] img, input logic s, input int lim);
		cfg_word = img;
		slow     = s;
		n_words  = 0;
		wr(`MRST_ADDR_STAT_RST, 16'h1000);
		@(negedge clk);
		chk({15'h0000, ready}, 16'h0000);
		wait_ready(lim);
		chk(n_words[15:0], 16'(`MRST_RELOAD_COUNT));
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		#900000;
		n_fail++;
		finish_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		resetn = 1'b0; ce = 1'b1; master_reset_n = 1'b1; store_busy_mode_pin = 1'b0;
		powerup_ram_test_skip = 1'b1; test_pin = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
		reg_addr = 16'h0000; reg_wdata = 16'h0000; cmd_valid = 1'b0; slow = 1'b0;
		cfg_word = 16'h0000; n_fail = 0; compares = 0; n_words = 0;
		repeat (16) @(posedge clk);
		@(negedge clk);
		resetn = 1'b1;
		// Power-up test, store-busy ended by config two bit 7
		mreset(1'b0, 1'b1);
		rdchk(`MRST_ADDR_CFG2, 16'h0080, 16'h0080);
		cmd(1'b1, 1'b0);
		wr(`MRST_ADDR_CFG2, 16'h0080);
		rdchk(`MRST_ADDR_CFG2, 16'h0080, 16'h0000);
		cmd(1'b0, 1'b0);
		// Skip test, store-busy ended by config one bits 4 and 6
		mreset(1'b1, 1'b1);
		rdchk(`MRST_ADDR_CFG2, 16'h0080, 16'h0080);
		wr(`MRST_ADDR_CFG1, 16'h0050);
		rdchk(`MRST_ADDR_CFG2, 16'h0080, 16'h0000);
		cmd(1'b0, 1'b0);
		wr(`MRST_ADDR_CFG1, 16'h0000);
		mreset(1'b1, 1'b0);
		rdchk(`MRST_ADDR_CFG2, 16'h0080, 16'h0000);
		// Soft reset with auto-start image
		wr(`MRST_ADDR_NEXT_PTR, 16'h1234);
		wr(`MRST_ADDR_LAST_PTR, 16'h4321);
		wr(`MRST_ADDR_TT_LO, 16'h5678);
		wr(`MRST_ADDR_TT_MID, 16'h9abc);
		wr(`MRST_ADDR_TT_HI, 16'h8765);
		rdchk(`MRST_ADDR_NEXT_PTR, 16'hffff, 16'h1234);
		rdchk(`MRST_ADDR_TT_HI, 16'hffff, 16'h8765);
		soft_reset(16'h0100, 1'b0, 5000);
		rdchk(`MRST_ADDR_STAT_RST, 16'h0001, 16'h0000);
		rdchk(`MRST_ADDR_TT_MID, 16'hffff, 16'h0000);
		rdchk(`MRST_ADDR_MON_PEND, 16'hffff, 16'h0000);
		rdchk(`MRST_ADDR_NEXT_PTR, 16'hffff, 16'h0000);
		rdchk(`MRST_ADDR_LAST_PTR, 16'hffff, 16'h0000);
		rdchk(`MRST_ADDR_TT_LO, 16'hffff, 16'h0000);
		rdchk(`MRST_ADDR_TT_HI, 16'hffff, 16'h0000);
		rdchk(`MRST_ADDR_HW_PEND, 16'h2002, 16'h0000);
		rdchk(`MRST_ADDR_CFG1, 16'h0100, 16'h0100);
		chk({15'h0000, mon_recording}, 16'h0000);
		cmd(1'b0, 1'b1);
		// Soft reset with plain image, slow store, manual start
		soft_reset(16'h0000, 1'b1, 12000);
		rdchk(`MRST_ADDR_STAT_RST, 16'h0001, 16'h0000);
		rdchk(`MRST_ADDR_CFG1, 16'h0100, 16'h0000);
		chk({15'h0000, mon_recording}, 16'h0000);
		wr(`MRST_ADDR_CFG1, 16'h0100);
		rdchk(`MRST_ADDR_CFG1, 16'h0100, 16'h0100);
		// Self-test control register
		wr(`MRST_ADDR_SELF_TEST, 16'h00fc);
		rdchk(`MRST_ADDR_SELF_TEST, 16'hffff, 16'h0000);
		@(negedge clk);
		test_pin = 1'b1;
		repeat (3) @(negedge clk);
		wr(`MRST_ADDR_SELF_TEST, 16'h03ff);
		chk({10'h000, loopback_ctrl}, 16'h003c);
		chk({15'h0000, loopback_en}, 16'h0001);
		rdchk(`MRST_ADDR_SELF_TEST, 16'hfcfc, 16'h00fc);
		wr(`MRST_ADDR_SELF_TEST, 16'h1400);
		for (int i = 0; i < 30000; i++) begin
			rd(`MRST_ADDR_SELF_TEST, rv);
			if (rv[9:8] !== 2'b00) break;
		end
		chk(rv & 16'h0300, 16'h0100);
		@(negedge clk);
		test_pin = 1'b0;
		repeat (3) @(negedge clk);
		rdchk(`MRST_ADDR_SELF_TEST, 16'hffff, 16'h0000);
		finish_test();
	end
endmodule
